// File: shared/turn_zone_defines.svh
// Register offsets, field positions and reset values for the turn/zone block
`ifndef TURN_ZONE_DEFINES_SVH
`define TURN_ZONE_DEFINES_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_GENERAL_SETUP 7'h00
`define ADDR_REFERENCE_SETUP 7'h01
`define ADDR_EVENT_FLAGS 7'h0E
`define ADDR_SOFT_LIMIT_LOW 7'h33
`define ADDR_SOFT_LIMIT_HIGH 7'h34
`define ADDR_LATCH_OR_TURNS 7'h36
`define ADDR_HALF_SPAN 7'h3A
`define ADDR_LIMIT_CTRL 7'h3B

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_SHOW_TURNS 0
`define BIT_WRAP_ENABLE 1
`define BIT_ENC_WRAP_ENABLE 0
`define BIT_LIMIT_LOW_EN 0
`define BIT_LIMIT_HIGH_EN 1
`define BIT_EV_LIMIT_LOW 0
`define BIT_EV_LIMIT_HIGH 1
`define BIT_RAMP_POSITIONING 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_WORD 32'h0000_0000

`endif

// File: shared/turn_zone_pkg.sv
// Types shared by the turn/zone block
`default_nettype none
package turn_zone_pkg;
	typedef enum logic [1:0] {
		DIR_HOLD = 2'b00,
		DIR_UP = 2'b01,
		DIR_DOWN = 2'b11
	} travel_dir_t;
endpackage : turn_zone_pkg
`default_nettype wire

// File: hw/wrap_tracker.sv
// Wrapping position register with revolution counter
`default_nettype none
module wrap_tracker
	import turn_zone_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wrap_en,
	input wire logic [WIDTH-1:0] half_span,
	input wire logic step_up,
	input wire logic step_down,
	output logic [WIDTH-1:0] position,
	output logic [WIDTH-1:0] turns
);
	if (WIDTH < 4) begin : g_width_check
		$error("wrap_tracker: WIDTH too small");
	end

	typedef struct packed {
		logic [WIDTH-1:0] pos;
		logic [WIDTH-1:0] turns;
	} st_t;

	st_t s_r;
	st_t s_nxt;
	logic active;
	logic [WIDTH-1:0] top;
	logic [WIDTH-1:0] bottom;

	assign active = wrap_en && (half_span != '0);
	assign top = half_span - WIDTH'(1);
	assign bottom = WIDTH'(0) - half_span;

	always_comb begin
		s_nxt = s_r;
		if (step_up && !step_down) begin
			if (active && s_r.pos == top) begin
				s_nxt.pos = bottom;
				s_nxt.turns = s_r.turns + WIDTH'(1);
			end else begin
				s_nxt.pos = s_r.pos + WIDTH'(1);
			end
		end else if (step_down && !step_up) begin
			if (active && s_r.pos == bottom) begin
				s_nxt.pos = top;
				s_nxt.turns = s_r.turns - WIDTH'(1);
			end else begin
				s_nxt.pos = s_r.pos - WIDTH'(1);
			end
		end
		// Counter is meaningless without wrapping, so it is held at zero
		if (!active) begin
			s_nxt.turns = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign position = s_r.pos;
	assign turns = s_r.turns;
endmodule : wrap_tracker
`default_nettype wire

// File: hw/turn_zone.sv
// Revolution counting and blocking-zone control of a ramp controller
//
// Contract
// - Wrap up adds a turn, down subtracts
// - Address 0x36 returns latched position by default
// - Show-turns bit swaps in revolution count
// - Turn count zero while wrapping inactive
// - Positioning picks direction avoiding the zone
// - Reaching a zone limit starts stop ramp
// - Low below high: inside if either holds
// - Low above high: inside if both hold
// - Reading event flags clears soft-limit events
// - Target outside zone: way avoiding it, resume
// - Encoder wrap bit wraps encoder position
// - Position spans minus span to span minus one
`include "turn_zone_defines.svh"
`default_nettype none
module turn_zone
	import turn_zone_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [2:0] ramp_kind,
	input wire logic [WIDTH-1:0] target_position,
	input wire logic [WIDTH-1:0] latch_value,
	input wire logic enc_up,
	input wire logic enc_down,
	output logic [WIDTH-1:0] actual_position,
	output logic [WIDTH-1:0] encoder_position,
	output logic step_pulse,
	output logic step_dir_up,
	output logic soft_stop
);
	if (WIDTH != 32) begin : g_width_check
		$error("turn_zone: WIDTH must match 32-bit bus");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] general_setup;
		logic [31:0] reference_setup;
		logic [31:0] event_flags;
		logic [31:0] soft_limit_low;
		logic [31:0] soft_limit_high;
		logic [31:0] half_span;
		logic [31:0] limit_ctrl;
		logic [31:0] rdata;
		logic step;
		logic dir_up;
		logic stop;
		logic was_in;
	} st_t;

	st_t s_r;
	st_t s_nxt;
	logic [WIDTH-1:0] pos;
	logic [WIDTH-1:0] turns;
	logic [WIDTH-1:0] enc_pos;
	logic [WIDTH-1:0] enc_turns;
	logic wrap_on;
	logic zone_on;
	logic positioning;
	logic at_zone;
	logic want_up;
	logic want_down;
	travel_dir_t dir;
	logic in_now;

	// Signed inside-zone test on a position
	function automatic logic in_zone(input logic [31:0] p,
			input logic [31:0] lo, input logic [31:0] hi);
		logic below;
		logic above;
		below = $signed(p) <= $signed(lo);
		above = $signed(p) >= $signed(hi);
		if ($signed(lo) < $signed(hi)) begin
			in_zone = below || above;
		end else begin
			in_zone = below && above;
		end
	endfunction : in_zone

	// Upward travel from p to x around the wrapped range; assumes both
	// lie inside that range, as limits and targets must
	function automatic logic [31:0] up_dist(input logic [31:0] x,
			input logic [31:0] p, input logic [31:0] span);
		logic [31:0] diff;
		diff = x - p;
		if (diff[31]) begin
			up_dist = diff + {span[30:0], 1'b0};
		end else begin
			up_dist = diff;
		end
	endfunction : up_dist

	// ----------------------------------------------------------------
	// Position trackers
	// ----------------------------------------------------------------
	wrap_tracker #(.WIDTH(WIDTH)) u_axis (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wrap_en(s_r.general_setup[`BIT_WRAP_ENABLE]),
		.half_span(s_r.half_span),
		.step_up(s_r.step && s_r.dir_up),
		.step_down(s_r.step && !s_r.dir_up),
		.position(pos),
		.turns(turns)
	);

	wrap_tracker #(.WIDTH(WIDTH)) u_encoder (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wrap_en(s_r.reference_setup[`BIT_ENC_WRAP_ENABLE]),
		.half_span(s_r.half_span),
		.step_up(enc_up),
		.step_down(enc_down),
		.position(enc_pos),
		.turns(enc_turns)
	);

	// ----------------------------------------------------------------
	// Zone and direction decision
	// ----------------------------------------------------------------
	assign wrap_on = s_r.general_setup[`BIT_WRAP_ENABLE] &&
		(s_r.half_span != '0);
	assign zone_on = wrap_on && s_r.limit_ctrl[`BIT_LIMIT_LOW_EN] &&
		s_r.limit_ctrl[`BIT_LIMIT_HIGH_EN];
	assign positioning = ramp_kind[`BIT_RAMP_POSITIONING];
	assign in_now = zone_on &&
		in_zone(pos, s_r.soft_limit_low, s_r.soft_limit_high);
	// Only arriving at a limit is an event, so leaving the zone stays possible
	assign at_zone = in_now && !s_r.was_in;

	always_comb begin
		dir = DIR_HOLD;
		if (!positioning) begin
			dir = DIR_UP;
		end else if (target_position != pos) begin
			if (wrap_on) begin
				// Shortest way around the circle; a tie goes upward
				dir = (up_dist(target_position, pos, s_r.half_span) >
					s_r.half_span) ? DIR_DOWN : DIR_UP;
			end else begin
				dir = ($signed(target_position) > $signed(pos)) ?
					DIR_UP : DIR_DOWN;
			end
			// The zone is the arc from the high limit up to the low one, so
			// the upward path crosses it if it meets the high limit first
			if (zone_on) begin
				if (up_dist(s_r.soft_limit_high, pos, s_r.half_span) <
						up_dist(target_position, pos, s_r.half_span)) begin
					dir = DIR_DOWN;
				end else begin
					dir = DIR_UP;
				end
			end
		end
	end

	assign want_up = dir == DIR_UP;
	assign want_down = dir == DIR_DOWN;

	// ----------------------------------------------------------------
	// Registers and motion
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.step = 1'b0;
		if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_GENERAL_SETUP: s_nxt.general_setup = reg_wdata;
				`ADDR_REFERENCE_SETUP: s_nxt.reference_setup = reg_wdata;
				`ADDR_SOFT_LIMIT_LOW: s_nxt.soft_limit_low = reg_wdata;
				`ADDR_SOFT_LIMIT_HIGH: s_nxt.soft_limit_high = reg_wdata;
				`ADDR_HALF_SPAN: s_nxt.half_span = reg_wdata;
				`ADDR_LIMIT_CTRL: s_nxt.limit_ctrl = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				`ADDR_GENERAL_SETUP: s_nxt.rdata = s_r.general_setup;
				`ADDR_REFERENCE_SETUP: s_nxt.rdata = s_r.reference_setup;
				`ADDR_EVENT_FLAGS: begin
					s_nxt.rdata = s_r.event_flags;
					s_nxt.event_flags = `RST_WORD;
				end
				`ADDR_SOFT_LIMIT_LOW: s_nxt.rdata = s_r.soft_limit_low;
				`ADDR_SOFT_LIMIT_HIGH: s_nxt.rdata = s_r.soft_limit_high;
				`ADDR_LATCH_OR_TURNS: begin
					if (s_r.general_setup[`BIT_SHOW_TURNS]) begin
						s_nxt.rdata = wrap_on ? turns : `RST_WORD;
					end else begin
						s_nxt.rdata = latch_value;
					end
				end
				`ADDR_HALF_SPAN: s_nxt.rdata = s_r.half_span;
				`ADDR_LIMIT_CTRL: s_nxt.rdata = s_r.limit_ctrl;
				default: s_nxt.rdata = `RST_WORD;
			endcase
		end
		// Reaching a limit sets the event; set wins over a same-cycle clear
		if (at_zone) begin
			s_nxt.stop = 1'b1;
			if (s_r.dir_up) begin
				s_nxt.event_flags[`BIT_EV_LIMIT_HIGH] = 1'b1;
			end else begin
				s_nxt.event_flags[`BIT_EV_LIMIT_LOW] = 1'b1;
			end
		end
		// Motion resumes only once events are cleared and target is outside
		if (s_r.stop && s_nxt.event_flags[1:0] == 2'b00 && positioning &&
				!(zone_on && in_zone(target_position, s_r.soft_limit_low,
				s_r.soft_limit_high))) begin
			s_nxt.stop = 1'b0;
		end
		s_nxt.was_in = in_now;
		// An idle cycle after each step lets the position land first, so no
		// decision is taken on a stale position; halves the top step rate
		if (!s_nxt.stop && !s_r.step && (want_up || want_down)) begin
			s_nxt.step = 1'b1;
			s_nxt.dir_up = want_up;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign actual_position = pos;
	assign encoder_position = enc_pos;
	assign step_pulse = s_r.step;
	assign step_dir_up = s_r.dir_up;
	assign soft_stop = s_r.stop;
endmodule : turn_zone
`default_nettype wire

// File: test/turn_zone_checker.sv
// Port-level assertions for the turn/zone block
`include "turn_zone_defines.svh"
`default_nettype none
module turn_zone_checker (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [6:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic [31:0] latch_value,
	input wire logic enc_up,
	input wire logic enc_down,
	input wire logic [31:0] actual_position,
	input wire logic [31:0] encoder_position,
	input wire logic step_pulse,
	input wire logic step_dir_up,
	input wire logic soft_stop
);
	logic [31:0] gen_r;
	logic [31:0] span_r;
	logic rd36;
	logic top_hit;
	logic bottom_hit;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	assign rd36 = reg_rd && reg_addr == `ADDR_LATCH_OR_TURNS;
	// Shadow copies, so reads can be judged against what was written
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gen_r <= '0;
			span_r <= '0;
		end else if (reg_wr && reg_addr == `ADDR_GENERAL_SETUP) begin
			gen_r <= reg_wdata;
		end else if (reg_wr && reg_addr == `ADDR_HALF_SPAN) begin
			span_r <= reg_wdata;
		end
	end
	assign top_hit = step_pulse && step_dir_up && gen_r[1] &&
		actual_position == span_r - 32'h1;
	assign bottom_hit = step_pulse && !step_dir_up && gen_r[1] &&
		actual_position == -span_r;
	sequence s_top_step;
		top_hit;
	endsequence
	sequence s_bottom_step;
		bottom_hit;
	endsequence
	a_latch_default: assert property (rd36 && !gen_r[0] |=>
		reg_rdata == $past(latch_value)) else $error("latch slot wrong");
	a_turns_idle: assert property (rd36 && gen_r[0] && !gen_r[1] |=>
		reg_rdata == 32'h0) else $error("idle turns not zero");
	a_stop_no_step: assert property (soft_stop |-> !step_pulse)
		else $error("step while stopped");
	a_wrap_top: assert property (s_top_step |=>
		actual_position == -span_r) else $error("top wrap wrong");
	a_wrap_bottom: assert property (s_bottom_step |=>
		actual_position == span_r - 32'h1) else $error("bottom wrap wrong");
	a_step_moves: assert property (step_pulse && !top_hit && !bottom_hit
		|=> actual_position == $past(actual_position)
		+ ($past(step_dir_up) ? 32'h1 : 32'hFFFF_FFFF)) else $error("bad step");
	a_enc_counts: assert property (enc_up && !enc_down |=>
		encoder_position != $past(encoder_position)) else $error("enc stuck");
	a_enc_quiet: assert property (!enc_up && !enc_down && !reg_wr |=>
		$stable(encoder_position)) else $error("enc drift");
endmodule : turn_zone_checker
bind turn_zone turn_zone_checker chk_u (.sys_clk, .sys_rst, .reg_wr, .reg_rd,
	.reg_addr, .reg_wdata, .reg_rdata, .latch_value, .enc_up, .enc_down,
	.actual_position, .encoder_position, .step_pulse, .step_dir_up, .soft_stop);
`default_nettype wire

// File: test/turn_zone_test.sv
// Self-checking bench for the turn/zone block
`include "turn_zone_defines.svh"
`default_nettype none
module turn_zone_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, sys_rst, reg_wr, reg_rd, enc_up, enc_down;
	logic step_pulse, step_dir_up, soft_stop;
	logic [6:0] reg_addr;
	logic [2:0] ramp_kind;
	logic [31:0] reg_wdata, reg_rdata, target_position, latch_value, d;
	logic [31:0] actual_position, encoder_position;
	int mismatches, checks_done;
	turn_zone dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .ramp_kind(ramp_kind),
		.target_position(target_position), .latch_value(latch_value),
		.enc_up(enc_up), .enc_down(enc_down),
		.actual_position(actual_position), .encoder_position(encoder_position),
		.step_pulse(step_pulse), .step_dir_up(step_dir_up),
		.soft_stop(soft_stop));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input string what, input logic [31:0] seen, input logic [31:0] e);
		checks_done++;
		if (seen !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, seen);
		end
	endtask : chk
	task wr(input logic [6:0] a, input logic [31:0] v);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = v;
		@(posedge sys_clk) #1;
		reg_wr = 1'b0;
		@(posedge sys_clk) #1;
	endtask : wr
	// Data is registered, so it is taken one edge after the strobe; an idle
	// edge follows so a second call never raises the strobe it just lowered
	task rd(input logic [6:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge sys_clk) #1;
		reg_rd = 1'b0;
		d = reg_rdata;
		@(posedge sys_clk) #1;
	endtask : rd
	task wait_stop;
		for (int i = 0; i < 40 && soft_stop !== 1'b1; i++)
			@(posedge sys_clk) #1;
	endtask : wait_stop
	task wait_at(input logic [31:0] p);
		for (int i = 0; i < 60 && actual_position !== p; i++) @(posedge sys_clk) #1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("position", actual_position, p);
	endtask : wait_at
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_slot;
		rd(`ADDR_LATCH_OR_TURNS);
		chk("latch", d, 32'h1234_5678);
		wr(`ADDR_GENERAL_SETUP, 32'h1);
		rd(`ADDR_LATCH_OR_TURNS);
		chk("idle turns", d, 32'h0);
		wr(`ADDR_HALF_SPAN, 32'h4);
		wr(`ADDR_GENERAL_SETUP, 32'h3);
		rd(`ADDR_LATCH_OR_TURNS);
		chk("turns", d, 32'h0);
	endtask : t_slot
	task t_wrap;
		ramp_kind = 3'h4;
		target_position = 32'h3;
		wait_at(32'h3);
		target_position = 32'hFFFF_FFFD;
		wait_at(32'hFFFF_FFFD);
		rd(`ADDR_LATCH_OR_TURNS);
		chk("turns up", d, 32'h1);
	endtask : t_wrap
	// Low limit above high limit: zone is 0..1, so -1 to 2 must go the
	// long way down through the wrap
	task t_zone;
		wr(`ADDR_SOFT_LIMIT_LOW, 32'h1);
		wr(`ADDR_SOFT_LIMIT_HIGH, 32'h0);
		wr(`ADDR_LIMIT_CTRL, 32'h3);
		target_position = 32'hFFFF_FFFF;
		wait_at(32'hFFFF_FFFF);
		target_position = 32'h2;
		wait_at(32'h2);
		rd(`ADDR_LATCH_OR_TURNS);
		chk("turns down", d, 32'h0);
	endtask : t_zone
	// Velocity mode runs up from 2 and must halt on the high limit at 0
	task t_stop;
		ramp_kind = 3'h0;
		wait_stop();
		d = actual_position;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("halted", actual_position, d);
		chk("halt point", d, 32'h0);
		chk("no step", {31'h0, step_pulse}, 32'h0);
		rd(`ADDR_EVENT_FLAGS);
		chk("high event", {31'h0, d[`BIT_EV_LIMIT_HIGH]}, 32'h1);
		ramp_kind = 3'h4;
		target_position = 32'hFFFF_FFFD;
		rd(`ADDR_EVENT_FLAGS);
		wait_at(32'hFFFF_FFFD);
		chk("stop", {31'h0, soft_stop}, 32'h0);
		chk("dir down", {31'h0, step_dir_up}, 32'h0);
	endtask : t_stop
	task t_enc;
		wr(`ADDR_REFERENCE_SETUP, 32'h1);
		enc_up = 1'b1;
		repeat (5) @(posedge sys_clk) #1;
		enc_up = 1'b0;
		@(posedge sys_clk) #1;
		chk("encoder", encoder_position, 32'hFFFF_FFFD);
	endtask : t_enc
	// Low limit below high limit: zone is 2 and up, or -4 and down
	task t_split_zone;
		wr(`ADDR_SOFT_LIMIT_LOW, 32'hFFFF_FFFC);
		wr(`ADDR_SOFT_LIMIT_HIGH, 32'h2);
		ramp_kind = 3'h0;
		wait_stop();
		chk("split stop", {31'h0, soft_stop}, 32'h1);
		chk("split limit", actual_position, 32'h2);
		rd(`ADDR_EVENT_FLAGS);
		chk("split event", {31'h0, d[`BIT_EV_LIMIT_HIGH]}, 32'h1);
	endtask : t_split_zone
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#5000;
		mismatches++;
		close_out();
	end
	initial begin
		{reg_wr, reg_rd, enc_up, enc_down, reg_addr, reg_wdata} = '0;
		// Positioning at target zero keeps the axis still through setup
		ramp_kind = 3'h4;
		target_position = '0;
		latch_value = 32'h1234_5678;
		sys_rst = 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		sys_rst = 1'b0;
		t_slot();
		t_wrap();
		t_zone();
		t_stop();
		t_enc();
		t_split_zone();
		close_out();
	end
endmodule : turn_zone_test
`default_nettype wire
